// file: logic/lcdcmd_pkg.sv
// Command codes, field layouts and fixed values of the LCD command interpreter
package lcdcmd_pkg;
  localparam logic [7:0] CMD_MEM_WRITE = 8'h5c;
  localparam logic [7:0] CMD_MEM_READ = 8'h5d;
  localparam logic [7:0] CMD_PARTIAL_ENTER = 8'ha8;
  localparam logic [7:0] CMD_PARTIAL_EXIT = 8'ha9;
  localparam logic [7:0] CMD_AREA_SCROLL_SETUP = 8'haa;
  localparam logic [7:0] CMD_SCROLL_START_BLOCK = 8'hab;
  localparam logic [7:0] CMD_RMW_ENTER = 8'he0;
  localparam logic [7:0] CMD_RMW_EXIT = 8'hee;
  localparam int CMD_LSB = 0;
  localparam int CMD_W = 8;
  localparam int BLOCK_W = 6;
  localparam int SCROLL_MODE_W = 2;
  localparam int BLOCK_LINES = 4;
  localparam int BLOCK_SHIFT = 2;
  localparam logic [5:0] TOP_FIXED_FIRST_BLOCK = 6'h00;
  localparam logic [5:0] BOTTOM_FIXED_FIRST_BLOCK = 6'h29;
  localparam logic [1:0] SCROLL_MODE_CENTRE = 2'h0;
  localparam logic SCAN_COLUMN = 1'b0;
  localparam logic SCAN_PAGE = 1'b1;

  typedef enum logic [3:0] {
    LCDCMD_IDLE,
    LCDCMD_WRITE,
    LCDCMD_READ,
    LCDCMD_PTL_START,
    LCDCMD_PTL_END,
    LCDCMD_ASC_TOP,
    LCDCMD_ASC_BOTTOM,
    LCDCMD_ASC_COUNT,
    LCDCMD_ASC_MODE,
    LCDCMD_SCROLL_START
  } lcdcmd_mode_e;
endpackage

// file: logic/lcdcmd_ram_if.sv
// Port bundle between the command core and the display memory
`timescale 1ns/1ps
`default_nettype none
interface lcdcmd_ram_if #(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 16
);
  logic we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: logic/lcdcmd_ram.sv
// Display memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_ram #(
  parameter int DEPTH = 22176,
  parameter int ADDR_W = 15,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  lcdcmd_ram_if.mem ram
);
  logic [DATA_W-1:0] mem_array [DEPTH];

  // Read data always from a register, written location reads old word
  always_ff @(posedge sys_clk) begin
    if (ram.we) begin
      mem_array[ram.addr] <= ram.wdata;
    end
    ram.rdata <= mem_array[ram.addr];
  end
endmodule
`default_nettype wire

// file: logic/lcdcmd_core.sv
// Command interpreter: display memory access, partial display and area scroll
// What this block does
// - Memory write command loads addresses outside modify mode, enters write
// - Memory read command loads addresses outside modify mode, enters read
// - Written word stored, address advances by scan
// - Any other command ends write or read
// - Select high for data, low for commands
// - Partial enter takes start and end block
// - Partial and scroll areas counted in blocks
// - Non-display line: off low, commons centre, segments fixed
// - Fixed segment level follows last displayed polarity
// - Frame polarity toggles every frame start
// - Partial exit ends partial display
// - Modify mode: reads hold address, writes advance
// - Modify mode ends on exit or other command
// - Scroll setup takes top, bottom, count, mode
// - Fixed areas from block 0 and block 41
// - Scroll start equals top until start command
// - Scroll start command takes one block number
// - Mode zero selects centre-screen scrolling
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_core
  import lcdcmd_pkg::*;
#(
  parameter int PAGES = 168,
  parameter int COLS = 132,
  parameter int PAGE_W = 8,
  parameter int COL_W = 8,
  parameter int DATA_W = 16,
  parameter int DISPLAY_LINES = 160,
  parameter int LINE_CYCLES = 64
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_data_select,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [DATA_W-1:0] bus_in,
  output logic [DATA_W-1:0] bus_out,
  output logic bus_oe,
  input wire logic scan_direction,
  input wire logic [PAGE_W-1:0] page_start,
  input wire logic [PAGE_W-1:0] page_end,
  input wire logic [COL_W-1:0] col_start,
  input wire logic [COL_W-1:0] col_end,
  output logic write_mode,
  output logic read_mode,
  output logic rmw_mode,
  output logic partial_mode,
  output logic [PAGE_W-1:0] page_addr,
  output logic [COL_W-1:0] col_addr,
  output logic [BLOCK_W-1:0] partial_start_block,
  output logic [BLOCK_W-1:0] partial_end_block,
  output logic [BLOCK_W-1:0] scroll_top_block,
  output logic [BLOCK_W-1:0] scroll_bottom_block,
  output logic [BLOCK_W-1:0] scroll_block_count,
  output logic [SCROLL_MODE_W-1:0] scroll_mode,
  output logic scroll_centre_mode,
  output logic [BLOCK_W-1:0] scroll_start_block,
  output logic [BLOCK_W-1:0] top_fixed_first_block,
  output logic [BLOCK_W-1:0] bottom_fixed_first_block,
  output logic frame_polarity,
  output logic display_off_out_n,
  output logic common_output_centre,
  output logic segment_output_fixed,
  output logic segment_output_positive
);
  localparam int DEPTH = PAGES * COLS;
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int LINE_W = $clog2(DISPLAY_LINES);
  localparam int CYC_W = $clog2(LINE_CYCLES);

  generate
    if (DATA_W != 16 || PAGES % BLOCK_LINES != 0 || PAGES > (1 << PAGE_W) ||
        COLS > (1 << COL_W) || DISPLAY_LINES > PAGES || LINE_CYCLES < 2) begin : g_bad
      $error("lcdcmd_core: unsupported parameter set");
    end
  endgenerate

  typedef struct packed {
    lcdcmd_mode_e mode;
    logic rmw;
    logic [PAGE_W-1:0] page;
    logic [COL_W-1:0] col;
    logic ptl_on;
    logic [BLOCK_W-1:0] ptl_start;
    logic [BLOCK_W-1:0] ptl_end;
    logic [BLOCK_W-1:0] ptl_start_new;
    logic [BLOCK_W-1:0] asc_top;
    logic [BLOCK_W-1:0] asc_bottom;
    logic [BLOCK_W-1:0] asc_count;
    logic [SCROLL_MODE_W-1:0] asc_mode;
    logic [BLOCK_W-1:0] scroll_start;
    logic [LINE_W-1:0] line;
    logic [CYC_W-1:0] cyc;
    logic polarity;
    logic last_polarity;
    logic disp_off_n;
    logic com_centre;
    logic seg_fixed;
    logic seg_positive;
  } lcdcmd_state_s;

  lcdcmd_state_s st_reg;
  lcdcmd_state_s st_next;
  lcdcmd_ram_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) ram_bus ();

  lcdcmd_ram #(.DEPTH(DEPTH), .ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_ram (
    .sys_clk(sys_clk),
    .ram(ram_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address step inside the window, wrapping at both ends
  function automatic logic [PAGE_W+COL_W-1:0] next_addr(
    input logic dir,
    input logic [PAGE_W-1:0] pg,
    input logic [COL_W-1:0] cl,
    input logic [PAGE_W-1:0] ps,
    input logic [PAGE_W-1:0] pe,
    input logic [COL_W-1:0] cs,
    input logic [COL_W-1:0] ce
  );
    logic [PAGE_W-1:0] np;
    logic [COL_W-1:0] nc;
    np = pg;
    nc = cl;
    if (dir == SCAN_COLUMN) begin
      nc = (cl == ce) ? cs : cl + 1'b1;
      if (cl == ce) begin
        np = (pg == pe) ? ps : pg + 1'b1;
      end
    end else begin
      np = (pg == pe) ? ps : pg + 1'b1;
      if (pg == pe) begin
        nc = (cl == ce) ? cs : cl + 1'b1;
      end
    end
    return {np, nc};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic cmd_wr;
  logic data_wr;
  logic data_rd;
  logic [CMD_W-1:0] cmd_code;
  logic [BLOCK_W-1:0] param_block;
  logic [BLOCK_W-1:0] line_block;
  logic non_display;
  logic frame_start;
  logic line_end;

  assign cmd_wr = wr_strobe && !cmd_data_select;
  assign data_wr = wr_strobe && cmd_data_select;
  assign data_rd = rd_strobe && cmd_data_select;
  assign cmd_code = bus_in[CMD_LSB +: CMD_W];
  assign param_block = bus_in[BLOCK_W-1:0];
  assign line_block = BLOCK_W'(st_reg.line >> BLOCK_SHIFT);
  assign non_display = st_reg.ptl_on &&
    (line_block < st_reg.ptl_start || line_block > st_reg.ptl_end);
  assign line_end = st_reg.cyc == CYC_W'(LINE_CYCLES - 1);
  assign frame_start = line_end && st_reg.line == LINE_W'(DISPLAY_LINES - 1);

  always_comb begin
    st_next = st_reg;
    if (cmd_wr) begin
      // Every command byte drops the data modes first
      st_next.mode = LCDCMD_IDLE;
      if (cmd_code != CMD_MEM_WRITE && cmd_code != CMD_MEM_READ) begin
        st_next.rmw = 1'b0;
      end
      unique case (cmd_code)
        CMD_MEM_WRITE: begin
          st_next.mode = LCDCMD_WRITE;
          if (!st_reg.rmw) begin
            st_next.page = page_start;
            st_next.col = col_start;
          end
        end
        CMD_MEM_READ: begin
          st_next.mode = LCDCMD_READ;
          if (!st_reg.rmw) begin
            st_next.page = page_start;
            st_next.col = col_start;
          end
        end
        CMD_RMW_ENTER: begin
          st_next.rmw = 1'b1;
          st_next.page = page_start;
          st_next.col = col_start;
        end
        CMD_PARTIAL_ENTER: st_next.mode = LCDCMD_PTL_START;
        CMD_PARTIAL_EXIT: st_next.ptl_on = 1'b0;
        CMD_AREA_SCROLL_SETUP: st_next.mode = LCDCMD_ASC_TOP;
        CMD_SCROLL_START_BLOCK: st_next.mode = LCDCMD_SCROLL_START;
        default: ;
      endcase
    end else if (data_wr) begin
      unique case (st_reg.mode)
        LCDCMD_WRITE: begin
          {st_next.page, st_next.col} = next_addr(scan_direction, st_reg.page, st_reg.col,
            page_start, page_end, col_start, col_end);
        end
        LCDCMD_PTL_START: begin
          st_next.ptl_start_new = param_block;
          st_next.mode = LCDCMD_PTL_END;
        end
        LCDCMD_PTL_END: begin
          // Range takes effect only once both blocks have arrived
          st_next.ptl_start = st_reg.ptl_start_new;
          st_next.ptl_end = param_block;
          st_next.ptl_on = 1'b1;
          st_next.mode = LCDCMD_IDLE;
        end
        LCDCMD_ASC_TOP: begin
          st_next.asc_top = param_block;
          st_next.scroll_start = param_block;
          st_next.mode = LCDCMD_ASC_BOTTOM;
        end
        LCDCMD_ASC_BOTTOM: begin
          st_next.asc_bottom = param_block;
          st_next.mode = LCDCMD_ASC_COUNT;
        end
        LCDCMD_ASC_COUNT: begin
          st_next.asc_count = param_block;
          st_next.mode = LCDCMD_ASC_MODE;
        end
        LCDCMD_ASC_MODE: begin
          st_next.asc_mode = bus_in[SCROLL_MODE_W-1:0];
          st_next.mode = LCDCMD_IDLE;
        end
        LCDCMD_SCROLL_START: begin
          st_next.scroll_start = param_block;
          st_next.mode = LCDCMD_IDLE;
        end
        LCDCMD_IDLE, LCDCMD_READ: ;
      endcase
    end else if (data_rd && st_reg.mode == LCDCMD_READ && !st_reg.rmw) begin
      // Modify mode keeps the address so the next write hits the read word
      {st_next.page, st_next.col} = next_addr(scan_direction, st_reg.page, st_reg.col,
        page_start, page_end, col_start, col_end);
    end

    // Line and frame timing
    st_next.cyc = line_end ? '0 : st_reg.cyc + 1'b1;
    if (line_end) begin
      st_next.line = frame_start ? '0 : st_reg.line + 1'b1;
    end
    if (frame_start) begin
      st_next.polarity = !st_reg.polarity;
    end
    if (!non_display) begin
      st_next.last_polarity = st_reg.polarity;
    end
    st_next.disp_off_n = !non_display;
    st_next.com_centre = non_display;
    st_next.seg_fixed = non_display;
    st_next.seg_positive = non_display ? st_reg.last_polarity : st_reg.polarity;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.mode <= LCDCMD_IDLE;
      st_reg.disp_off_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory port: read data follow the current address one cycle later
  assign ram_bus.we = data_wr && st_reg.mode == LCDCMD_WRITE;
  assign ram_bus.addr = ADDR_W'(st_reg.page * COLS + st_reg.col);
  assign ram_bus.wdata = bus_in;

  assign bus_out = ram_bus.rdata;
  assign bus_oe = data_rd && st_reg.mode == LCDCMD_READ;
  assign write_mode = st_reg.mode == LCDCMD_WRITE;
  assign read_mode = st_reg.mode == LCDCMD_READ;
  assign rmw_mode = st_reg.rmw;
  assign partial_mode = st_reg.ptl_on;
  assign page_addr = st_reg.page;
  assign col_addr = st_reg.col;
  assign partial_start_block = st_reg.ptl_start;
  assign partial_end_block = st_reg.ptl_end;
  assign scroll_top_block = st_reg.asc_top;
  assign scroll_bottom_block = st_reg.asc_bottom;
  assign scroll_block_count = st_reg.asc_count;
  assign scroll_mode = st_reg.asc_mode;
  assign scroll_centre_mode = st_reg.asc_mode == SCROLL_MODE_CENTRE;
  assign scroll_start_block = st_reg.scroll_start;
  assign top_fixed_first_block = TOP_FIXED_FIRST_BLOCK;
  assign bottom_fixed_first_block = BOTTOM_FIXED_FIRST_BLOCK;
  assign frame_polarity = st_reg.polarity;
  assign display_off_out_n = st_reg.disp_off_n;
  assign common_output_centre = st_reg.com_centre;
  assign segment_output_fixed = st_reg.seg_fixed;
  assign segment_output_positive = st_reg.seg_positive;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_write_cmd;
    cmd_wr && cmd_code == CMD_MEM_WRITE && !rmw_mode |=>
      write_mode && page_addr == $past(page_start) && col_addr == $past(col_start);
  endproperty
  a_write_cmd: assert property (p_write_cmd) else $error("write cmd load");

  property p_read_cmd;
    cmd_wr && cmd_code == CMD_MEM_READ && !rmw_mode |=>
      read_mode && page_addr == $past(page_start) && col_addr == $past(col_start);
  endproperty
  a_read_cmd: assert property (p_read_cmd) else $error("read cmd load");

  property p_data_store;
    data_wr && write_mode |-> ram_bus.we ##1 (page_addr != $past(page_addr) ||
      col_addr != $past(col_addr) || (page_start == page_end && col_start == col_end));
  endproperty
  a_data_store: assert property (p_data_store) else $error("write not stored");

  property p_other_cmd;
    cmd_wr && cmd_code != CMD_MEM_WRITE && cmd_code != CMD_MEM_READ &&
      cmd_code != CMD_RMW_ENTER |=>
      !write_mode && !read_mode && !rmw_mode;
  endproperty
  a_other_cmd: assert property (p_other_cmd) else $error("mode not left");

  property p_rmw_read_hold;
    data_rd && read_mode && rmw_mode |=> $stable(page_addr) && $stable(col_addr);
  endproperty
  a_rmw_read_hold: assert property (p_rmw_read_hold) else $error("rmw read moved");

  property p_partial_exit;
    cmd_wr && cmd_code == CMD_PARTIAL_EXIT |=> !partial_mode;
  endproperty
  a_partial_exit: assert property (p_partial_exit) else $error("partial not left");

  property p_frame_toggle;
    frame_start |=> frame_polarity != $past(frame_polarity);
  endproperty
  a_frame_toggle: assert property (p_frame_toggle) else $error("no polarity flip");

  property p_non_display;
    non_display |=> !display_off_out_n && common_output_centre && segment_output_fixed;
  endproperty
  a_non_display: assert property (p_non_display) else $error("non-display drive");

  property p_scroll_top;
    data_wr && st_reg.mode == LCDCMD_ASC_TOP |=>
      scroll_start_block == scroll_top_block ##1 st_reg.mode != LCDCMD_ASC_TOP;
  endproperty
  a_scroll_top: assert property (p_scroll_top) else $error("scroll start != top");
endmodule
`default_nettype wire

// file: dv/lcdcmd_host.sv
// Host processor model driving the command/data bus
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_host (
  input wire logic sys_clk,
  input wire logic [15:0] bus_out,
  input wire logic bus_oe,
  output var logic cmd_data_select,
  output var logic wr_strobe,
  output var logic rd_strobe,
  output var logic [15:0] bus_in
);
  initial begin
    cmd_data_select = 1'b1;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    bus_in = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One word per strobe; ends at the falling edge so state has settled
  task automatic put(input logic sel, input logic [15:0] w);
    @(posedge sys_clk);
    cmd_data_select <= sel;
    wr_strobe <= 1'b1;
    bus_in <= w;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
    // Released bus must not keep showing the last word
    bus_in <= ~w;
    @(negedge sys_clk);
  endtask
  task automatic get(output logic [15:0] d, output logic oe);
    @(posedge sys_clk);
    cmd_data_select <= 1'b1;
    rd_strobe <= 1'b1;
    @(negedge sys_clk);
    d = bus_out;
    oe = bus_oe;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    @(negedge sys_clk);
  endtask
  // Upper byte carries junk, only the low byte names the command
  task automatic cmd(input logic [7:0] c);
    put(1'b0, {8'($urandom), c});
  endtask
  // Block fields sit in the low six bits, junk above
  task automatic prm(input logic [5:0] p);
    put(1'b1, {10'($urandom), p});
  endtask
endmodule
`default_nettype wire

// file: dv/test_lcd_ram_access_partial_scroll.sv
// Self-checking bench for the LCD command interpreter
`timescale 1ns/1ps
`default_nettype none
module test_lcd_ram_access_partial_scroll;
  import lcdcmd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_data_select, wr_strobe, rd_strobe, bus_oe;
  logic [15:0] bus_in, bus_out;
  logic scan_direction = 1'b0;
  logic [7:0] page_start = 8'h00, page_end = 8'h01, col_start = 8'h00, col_end = 8'h02;
  logic write_mode, read_mode, rmw_mode, partial_mode, scroll_centre_mode;
  logic [7:0] page_addr, col_addr;
  logic [5:0] partial_start_block, partial_end_block, scroll_top_block, scroll_bottom_block;
  logic [5:0] scroll_block_count, scroll_start_block, top_fixed_first_block;
  logic [5:0] bottom_fixed_first_block;
  logic [1:0] scroll_mode;
  logic frame_polarity, display_off_out_n, common_output_centre, segment_output_fixed;
  logic segment_output_positive;
  int num_errors = 0;
  int checked = 0;
  logic [7:0] exp_pg, exp_cl;
  logic [15:0] mem [logic [15:0]];
  logic [15:0] w, d;
  logic oe, last_pol, pol_d;
  logic [5:0] top, bot, cnt, sb;
  logic [5:0] ps [3] = '{6'h01, 6'h00, 6'h00};
  logic [5:0] pe [3] = '{6'h01, 6'h00, 6'h01};
  int lows [3] = '{160, 160, 0};

  always #5 sys_clk = ~sys_clk;

  // Short lines and frames keep the display checks brief
  lcdcmd_core #(.LINE_CYCLES(4), .DISPLAY_LINES(8)) lcdcmd_core_inst (
    .sys_clk, .rst_n, .cmd_data_select, .wr_strobe, .rd_strobe, .bus_in, .bus_out, .bus_oe,
    .scan_direction, .page_start, .page_end, .col_start, .col_end, .write_mode, .read_mode,
    .rmw_mode, .partial_mode, .page_addr, .col_addr, .partial_start_block,
    .partial_end_block, .scroll_top_block, .scroll_bottom_block, .scroll_block_count,
    .scroll_mode, .scroll_centre_mode, .scroll_start_block, .top_fixed_first_block,
    .bottom_fixed_first_block, .frame_polarity, .display_off_out_n, .common_output_centre,
    .segment_output_fixed, .segment_output_positive);
  lcdcmd_host lcdcmd_host_inst (.sys_clk, .bus_out, .bus_oe, .cmd_data_select, .wr_strobe,
    .rd_strobe, .bus_in);

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_addr();
    chk({page_addr, col_addr}, {exp_pg, exp_cl}, "address");
  endtask
  // Expected counter move, wrapping at the window edges
  function automatic void step();
    if (scan_direction == SCAN_COLUMN) begin
      if (exp_cl == col_end) begin
        exp_cl = col_start;
        exp_pg = (exp_pg == page_end) ? page_start : exp_pg + 8'h01;
      end else exp_cl = exp_cl + 8'h01;
    end else begin
      if (exp_pg == page_end) begin
        exp_pg = page_start;
        exp_cl = (exp_cl == col_end) ? col_start : exp_cl + 8'h01;
      end else exp_pg = exp_pg + 8'h01;
    end
  endfunction
  // Blanking output lags the polarity by one cycle, so pair it with the delayed copy
  always @(negedge sys_clk) begin
    pol_d <= frame_polarity;
    if (display_off_out_n === 1'b1) last_pol <= pol_d;
  end
  task automatic watch(input int n_exp);
    int n_low, n_tog;
    logic prev;
    n_low = 0;
    n_tog = 0;
    repeat (40) @(negedge sys_clk);
    prev = frame_polarity;
    repeat (320) begin
      @(negedge sys_clk);
      if (frame_polarity !== prev) n_tog++;
      prev = frame_polarity;
      if (display_off_out_n === 1'b0) begin
        n_low++;
        chk(16'({common_output_centre, segment_output_fixed, segment_output_positive}),
            16'({2'b11, last_pol}), "blank line levels");
      end else begin
        chk(16'({common_output_centre, segment_output_fixed}), 16'h0000, "shown line");
      end
    end
    chk(16'(n_low), 16'(n_exp), "blank cycles");
    chk(16'(n_tog), 16'h000a, "polarity toggles");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hc2445e49));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk(16'({write_mode, read_mode, rmw_mode, partial_mode, display_off_out_n}), 16'h0001,
        "reset state");
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      scan_direction <= s[0];
      page_start <= 8'($urandom_range(0, 150));
      col_start <= 8'($urandom_range(0, 120));
      @(posedge sys_clk);
      page_end <= page_start + 8'h01;
      col_end <= col_start + 8'h02;
      lcdcmd_host_inst.cmd(CMD_MEM_WRITE);
      exp_pg = page_start;
      exp_cl = col_start;
      chk(16'(write_mode), 16'h0001, "write mode on");
      chk_addr();
      // Fourteen words wrap a six-word window twice
      for (int n = 0; n < 14; n++) begin
        w = 16'($urandom);
        mem[{exp_pg, exp_cl}] = w;
        lcdcmd_host_inst.put(1'b1, w);
        step();
        chk_addr();
      end
      lcdcmd_host_inst.cmd(CMD_MEM_READ);
      exp_pg = page_start;
      exp_cl = col_start;
      chk(16'({write_mode, read_mode}), 16'h0001, "read mode on");
      chk_addr();
      for (int n = 0; n < 7; n++) begin
        lcdcmd_host_inst.get(d, oe);
        chk(d, mem[{exp_pg, exp_cl}], "read word");
        chk(16'(oe), 16'h0001, "bus driven");
        step();
        chk_addr();
      end
      lcdcmd_host_inst.cmd(8'h00);
      chk(16'({write_mode, read_mode}), 16'h0000, "modes left");
      lcdcmd_host_inst.get(d, oe);
      chk(16'(oe), 16'h0000, "bus released");
      lcdcmd_host_inst.put(1'b1, 16'($urandom));
      chk_addr();
    end
    // Window was set before entering modify mode
    lcdcmd_host_inst.cmd(CMD_RMW_ENTER);
    exp_pg = page_start;
    exp_cl = col_start;
    chk(16'(rmw_mode), 16'h0001, "modify mode on");
    chk_addr();
    lcdcmd_host_inst.cmd(CMD_MEM_READ);
    lcdcmd_host_inst.get(d, oe);
    chk(d, mem[{exp_pg, exp_cl}], "modify read");
    chk_addr();
    lcdcmd_host_inst.cmd(CMD_MEM_WRITE);
    lcdcmd_host_inst.put(1'b1, ~d);
    step();
    chk_addr();
    chk(16'(rmw_mode), 16'h0001, "modify mode kept");
    lcdcmd_host_inst.cmd(CMD_RMW_EXIT);
    chk(16'(rmw_mode), 16'h0000, "modify exit");
    lcdcmd_host_inst.cmd(CMD_RMW_ENTER);
    lcdcmd_host_inst.cmd(CMD_PARTIAL_EXIT);
    chk(16'(rmw_mode), 16'h0000, "modify ended by other");
    // Only blocks 0 and 1 are scanned in this frame size
    for (int i = 0; i < 3; i++) begin
      lcdcmd_host_inst.cmd(CMD_PARTIAL_ENTER);
      lcdcmd_host_inst.prm(ps[i]);
      lcdcmd_host_inst.prm(pe[i]);
      chk(16'({partial_mode, partial_start_block, partial_end_block}),
          16'({1'b1, ps[i], pe[i]}), "partial range");
      watch(lows[i]);
    end
    lcdcmd_host_inst.cmd(CMD_PARTIAL_EXIT);
    chk(16'(partial_mode), 16'h0000, "partial exit");
    watch(0);
    for (int m = 0; m < 4; m++) begin
      if (m == 0) begin
        top = 6'($urandom_range(1, 19));
        bot = 6'($urandom_range(21, 40));
        cnt = 6'($urandom_range(top, bot));
      end else begin
        top = 6'h00;
        bot = 6'h29;
        cnt = 6'h29;
      end
      lcdcmd_host_inst.cmd(CMD_AREA_SCROLL_SETUP);
      lcdcmd_host_inst.prm(top);
      chk(16'(scroll_start_block), 16'(top), "start follows top");
      lcdcmd_host_inst.prm(bot);
      lcdcmd_host_inst.prm(cnt);
      lcdcmd_host_inst.prm({4'($urandom), m[1:0]});
      chk({4'h0, scroll_top_block, scroll_bottom_block}, {4'h0, top, bot}, "top bottom");
      chk(16'({scroll_block_count, scroll_mode}), 16'({cnt, m[1:0]}), "count mode");
      chk(16'(scroll_centre_mode), 16'(m == 0), "centre mode");
      chk(16'(scroll_start_block), 16'(top), "start held");
      chk({4'h0, top_fixed_first_block, bottom_fixed_first_block}, 16'h0029, "fixed");
      lcdcmd_host_inst.cmd(CMD_SCROLL_START_BLOCK);
      sb = 6'($urandom_range(top, bot));
      lcdcmd_host_inst.prm(sb);
      chk(16'(scroll_start_block), 16'(sb), "scroll start");
    end
    end_sim();
  end
endmodule
`default_nettype wire
